// File: logic/cctu_params.svh
`ifndef CCTU_PARAMS_SVH
`define CCTU_PARAMS_SVH

// Register byte offsets.
`define CCTU_OFF_CTRL      6'h00
`define CCTU_OFF_PERIOD    6'h04
`define CCTU_OFF_MONO0     6'h08
`define CCTU_OFF_MONO1     6'h0c
`define CCTU_OFF_DELAY     6'h10
`define CCTU_OFF_EVT_CUR   6'h14
`define CCTU_OFF_EVT_PREV  6'h18
`define CCTU_OFF_OPTO      6'h1c
`define CCTU_OFF_STATUS    6'h20

// Control register fields.
`define CCTU_CTRL_ENABLE   0
`define CCTU_CTRL_LSCAN    1
`define CCTU_CTRL_EDGE     2
`define CCTU_CTRL_SRC_LO   3
`define CCTU_CTRL_SRC_HI   5
`define CCTU_CTRL_DLY_LINE 8
`define CCTU_CTRL_EVT_LO   9
`define CCTU_CTRL_EVT_HI   10
`define CCTU_CTRL_GATE_LO  11
`define CCTU_CTRL_GATE_HI  12

// Opto output configuration fields.
`define CCTU_OPTO_SRC0_LO  0
`define CCTU_OPTO_SRC0_HI  1
`define CCTU_OPTO_SRC1_LO  2
`define CCTU_OPTO_SRC1_HI  3
`define CCTU_OPTO_SW_LO    4
`define CCTU_OPTO_SW_HI    5

// Reset values.
`define CCTU_RST_CTRL      32'h0000_0000
`define CCTU_RST_PERIOD    32'h0000_0001
`define CCTU_RST_WIDTH     32'h0000_0000
`define CCTU_RST_OPTO      32'h0000_0000

// Timing.
`define CCTU_CLK_NS        4
`define CCTU_US_NS         1000
`define CCTU_US_CYC        (`CCTU_US_NS / `CCTU_CLK_NS)
`define CCTU_AST_MIN_US    32'h0000_0001
`define CCTU_AST_MAX_MIN   70
`define CCTU_AST_MAX_US    (32'(64'(`CCTU_AST_MAX_MIN) * 64'd60 * 64'd1000000))

`endif

// File: logic/cctu_pkg.sv
package cctu_pkg;

  typedef enum logic [0:0] {
    CCTU_DLY_IDLE = 1'b0,
    CCTU_DLY_WAIT = 1'b1
  } cctu_dly_e;

  typedef enum logic [1:0] {
    CCTU_OSRC_SW    = 2'b00,
    CCTU_OSRC_AST   = 2'b01,
    CCTU_OSRC_MONO0 = 2'b10,
    CCTU_OSRC_TRIG  = 2'b11
  } cctu_osrc_e;

  typedef enum logic [1:0] {
    CCTU_EVT_LINE  = 2'b00,
    CCTU_EVT_FRAME = 2'b01,
    CCTU_EVT_US    = 2'b10
  } cctu_evt_e;

  typedef enum logic [1:0] {
    CCTU_GATE_LINE  = 2'b00,
    CCTU_GATE_FRAME = 2'b01,
    CCTU_GATE_TRIG  = 2'b10,
    CCTU_GATE_ACQ   = 2'b11
  } cctu_gate_e;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] period;
    logic [31:0] mono0_w;
    logic [31:0] mono1_w;
    logic [31:0] delay_v;
    logic [31:0] opto_cfg;
    logic [7:0]  div_cnt;
    logic        tick;
    logic        trig_prev;
    logic        lv_prev;
    logic        fv_prev;
    logic        gate_prev;
    cctu_dly_e   dly_state;
    logic [31:0] dly_cnt;
    logic [31:0] ast_cnt;
    logic [31:0] m0_cnt;
    logic [31:0] m1_cnt;
    logic [31:0] evt_cur;
    logic [31:0] evt_prev;
    logic        exp_out;
    logic        pix_out;
    logic        dtrig;
    logic        ast_pulse;
    logic [1:0]  opto_out;
    logic [31:0] rdata;
    logic        ack;
    logic        waitreq;
  } cctu_state_s;

endpackage

// File: logic/cctu_top.sv
`timescale 1ns/1ps
`include "cctu_params.svh"
// Operation
// - Five independent 32-bit timers serve as astable, dual monostable, trigger delay and event counter.
// - The astable emits a periodic pulse used as line rate or area-scan acquisition trigger.
// - The astable period is set in 1 us steps from 1 us up to 70 minutes.
// - Two monostables drive the exposure sync pulse and the pixel reset pulse.
// - Both monostables start on the same delayed trigger, each with its own width in 1 us units.
// - The trigger delay postpones the trigger by a count of microseconds or of camera lines.
// - The trigger delay is non-retriggerable and drops triggers while a delay is pending.
// - The event counter counts lines, frames or ticks only inside a line, frame, trigger or acquisition gate.
// - The event counter exposes the running count and the total captured at the previous gate end.
// - The opto interface has four bits, built as two inputs and two outputs.
// - Each opto output picks software level, a timer output or the forwarded trigger.
// - The trigger is level or edge sensitive and comes from an opto or differential input.
// - In line-scan mode lines come from line valid alone and frame valid may act as a trigger.
module cctu_top (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  input  wire logic [5:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_frame_valid,
  input  wire logic        i_line_valid,
  input  wire logic [1:0]  i_opto_in,
  input  wire logic [1:0]  i_diff_in,
  output logic             o_exposure_sync_pulse,
  output logic             o_pixel_reset_pulse,
  output logic             o_delayed_trigger,
  output logic             o_astable_pulse,
  output logic      [1:0]  o_opto_out
);

  localparam logic [7:0] US_LAST = 8'(`CCTU_US_CYC - 1);

  cctu_pkg::cctu_state_s s;
  cctu_pkg::cctu_state_s next_s;

  logic        trig_raw;
  logic        trig_ev;
  logic        line_ev;
  logic        frame_ev;
  logic        gate;
  logic        gate_end;
  logic        cnt_ev;
  logic        dly_ev;
  logic        enable;
  logic [31:0] period_eff;

  function automatic logic rise(input logic cur, input logic prev);
    rise = cur & ~prev;
  endfunction

  function automatic logic opto_pick(input logic [1:0] src, input logic sw,
                                     input logic ast, input logic m0, input logic tr);
    case (cctu_pkg::cctu_osrc_e'(src))
      cctu_pkg::CCTU_OSRC_SW:    opto_pick = sw;
      cctu_pkg::CCTU_OSRC_AST:   opto_pick = ast;
      cctu_pkg::CCTU_OSRC_MONO0: opto_pick = m0;
      cctu_pkg::CCTU_OSRC_TRIG:  opto_pick = tr;
      default:                   opto_pick = sw;
    endcase
  endfunction

  always_comb begin
    enable = s.ctrl[`CCTU_CTRL_ENABLE];
    // Selector values 0..3 are opto and differential inputs; 4 is frame valid in line-scan.
    case (s.ctrl[`CCTU_CTRL_SRC_HI:`CCTU_CTRL_SRC_LO])
      3'h0:    trig_raw = i_opto_in[0];
      3'h1:    trig_raw = i_opto_in[1];
      3'h2:    trig_raw = i_diff_in[0];
      3'h3:    trig_raw = i_diff_in[1];
      3'h4:    trig_raw = s.ctrl[`CCTU_CTRL_LSCAN] & i_frame_valid;
      default: trig_raw = 1'b0;
    endcase
    trig_ev = enable & (s.ctrl[`CCTU_CTRL_EDGE] ? rise(trig_raw, s.trig_prev) : trig_raw);
    // Line boundaries come from line valid alone, in either scan mode.
    line_ev  = rise(i_line_valid, s.lv_prev);
    frame_ev = rise(i_frame_valid, s.fv_prev);
    case (cctu_pkg::cctu_gate_e'(s.ctrl[`CCTU_CTRL_GATE_HI:`CCTU_CTRL_GATE_LO]))
      cctu_pkg::CCTU_GATE_LINE:  gate = i_line_valid;
      cctu_pkg::CCTU_GATE_FRAME: gate = i_frame_valid;
      cctu_pkg::CCTU_GATE_TRIG:  gate = trig_raw;
      cctu_pkg::CCTU_GATE_ACQ:   gate = enable;
      default:                   gate = 1'b0;
    endcase
    gate_end = s.gate_prev & ~gate;
    case (cctu_pkg::cctu_evt_e'(s.ctrl[`CCTU_CTRL_EVT_HI:`CCTU_CTRL_EVT_LO]))
      cctu_pkg::CCTU_EVT_LINE:  cnt_ev = line_ev;
      cctu_pkg::CCTU_EVT_FRAME: cnt_ev = frame_ev;
      cctu_pkg::CCTU_EVT_US:    cnt_ev = s.tick;
      default:                  cnt_ev = 1'b0;
    endcase
    dly_ev = s.ctrl[`CCTU_CTRL_DLY_LINE] ? line_ev : s.tick;
    // A zero period would stall the astable, so it is clamped into the legal range.
    if (s.period < `CCTU_AST_MIN_US) begin
      period_eff = `CCTU_AST_MIN_US;
    end else if (s.period > `CCTU_AST_MAX_US) begin
      period_eff = `CCTU_AST_MAX_US;
    end else begin
      period_eff = s.period;
    end
  end

  always_comb begin
    next_s = s;
    next_s.trig_prev = trig_raw;
    next_s.lv_prev   = i_line_valid;
    next_s.fv_prev   = i_frame_valid;
    next_s.gate_prev = gate;

    // Microsecond timebase.
    next_s.tick = 1'b0;
    if (s.div_cnt == US_LAST) begin
      next_s.div_cnt = 8'h00;
      next_s.tick    = 1'b1;
    end else begin
      next_s.div_cnt = s.div_cnt + 8'h01;
    end

    // Astable: wraps every period_eff ticks and marks the wrap with one clock pulse.
    next_s.ast_pulse = 1'b0;
    if (!enable) begin
      next_s.ast_cnt = 32'h0000_0000;
    end else if (s.tick) begin
      if (s.ast_cnt >= period_eff - 32'h0000_0001) begin
        next_s.ast_cnt   = 32'h0000_0000;
        next_s.ast_pulse = 1'b1;
      end else begin
        next_s.ast_cnt = s.ast_cnt + 32'h0000_0001;
      end
    end

    // Trigger delay; triggers arriving while a delay is pending are dropped.
    next_s.dtrig = 1'b0;
    case (s.dly_state)
      cctu_pkg::CCTU_DLY_IDLE: begin
        if (trig_ev) begin
          if (s.delay_v == 32'h0000_0000) begin
            next_s.dtrig = 1'b1;
          end else begin
            next_s.dly_cnt   = s.delay_v;
            next_s.dly_state = cctu_pkg::CCTU_DLY_WAIT;
          end
        end
      end
      cctu_pkg::CCTU_DLY_WAIT: begin
        if (dly_ev) begin
          if (s.dly_cnt <= 32'h0000_0001) begin
            next_s.dly_cnt   = 32'h0000_0000;
            next_s.dtrig     = 1'b1;
            next_s.dly_state = cctu_pkg::CCTU_DLY_IDLE;
          end else begin
            next_s.dly_cnt = s.dly_cnt - 32'h0000_0001;
          end
        end
      end
      default: begin
        next_s.dly_state = cctu_pkg::CCTU_DLY_IDLE;
        next_s.dly_cnt   = 32'h0000_0000;
      end
    endcase

    // Both monostables load on the delayed trigger and count down on the tick.
    if (s.dtrig) begin
      next_s.m0_cnt = s.mono0_w;
      next_s.m1_cnt = s.mono1_w;
    end else if (s.tick) begin
      if (s.m0_cnt != 32'h0000_0000) begin
        next_s.m0_cnt = s.m0_cnt - 32'h0000_0001;
      end
      if (s.m1_cnt != 32'h0000_0000) begin
        next_s.m1_cnt = s.m1_cnt - 32'h0000_0001;
      end
    end
    next_s.exp_out = next_s.m0_cnt != 32'h0000_0000;
    next_s.pix_out = next_s.m1_cnt != 32'h0000_0000;

    // Event counter; the closing gate's own event is not counted.
    if (gate_end) begin
      next_s.evt_prev = s.evt_cur;
      next_s.evt_cur  = 32'h0000_0000;
    end else if (gate && cnt_ev) begin
      next_s.evt_cur = s.evt_cur + 32'h0000_0001;
    end

    next_s.opto_out[0] = opto_pick(s.opto_cfg[`CCTU_OPTO_SRC0_HI:`CCTU_OPTO_SRC0_LO],
                                   s.opto_cfg[`CCTU_OPTO_SW_LO], s.ast_pulse,
                                   s.exp_out, s.dtrig);
    next_s.opto_out[1] = opto_pick(s.opto_cfg[`CCTU_OPTO_SRC1_HI:`CCTU_OPTO_SRC1_LO],
                                   s.opto_cfg[`CCTU_OPTO_SW_HI], s.ast_pulse,
                                   s.exp_out, s.dtrig);

    // Bus: one wait cycle, then waitrequest low for one cycle; writes land on that edge.
    next_s.ack     = (i_avs_read | i_avs_write) & ~s.ack;
    next_s.waitreq = ~next_s.ack;
    if (next_s.ack && i_avs_read) begin
      case (i_avs_address)
        `CCTU_OFF_CTRL:     next_s.rdata = s.ctrl;
        `CCTU_OFF_PERIOD:   next_s.rdata = s.period;
        `CCTU_OFF_MONO0:    next_s.rdata = s.mono0_w;
        `CCTU_OFF_MONO1:    next_s.rdata = s.mono1_w;
        `CCTU_OFF_DELAY:    next_s.rdata = s.delay_v;
        `CCTU_OFF_EVT_CUR:  next_s.rdata = s.evt_cur;
        `CCTU_OFF_EVT_PREV: next_s.rdata = s.evt_prev;
        `CCTU_OFF_OPTO:     next_s.rdata = s.opto_cfg;
        `CCTU_OFF_STATUS:   next_s.rdata = {25'h0, s.exp_out, s.pix_out,
                                            s.dly_state == cctu_pkg::CCTU_DLY_WAIT,
                                            i_diff_in, i_opto_in};
        default:            next_s.rdata = 32'h0000_0000;
      endcase
    end
    if (s.ack && i_avs_write) begin
      case (i_avs_address)
        `CCTU_OFF_CTRL:   next_s.ctrl     = i_avs_writedata;
        `CCTU_OFF_PERIOD: next_s.period   = i_avs_writedata;
        `CCTU_OFF_MONO0:  next_s.mono0_w  = i_avs_writedata;
        `CCTU_OFF_MONO1:  next_s.mono1_w  = i_avs_writedata;
        `CCTU_OFF_DELAY:  next_s.delay_v  = i_avs_writedata;
        `CCTU_OFF_OPTO:   next_s.opto_cfg = i_avs_writedata;
        default:          next_s.ctrl     = s.ctrl;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s          <= '0;
      s.ctrl     <= `CCTU_RST_CTRL;
      s.period   <= `CCTU_RST_PERIOD;
      s.mono0_w  <= `CCTU_RST_WIDTH;
      s.mono1_w  <= `CCTU_RST_WIDTH;
      s.opto_cfg <= `CCTU_RST_OPTO;
      s.waitreq  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign o_avs_readdata        = s.rdata;
  assign o_avs_waitrequest     = s.waitreq;
  assign o_exposure_sync_pulse = s.exp_out;
  assign o_pixel_reset_pulse   = s.pix_out;
  assign o_delayed_trigger     = s.dtrig;
  assign o_astable_pulse       = s.ast_pulse;
  assign o_opto_out            = s.opto_out;

  a_tick_spacing: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    s.tick |=> !s.tick ##248 !s.tick ##1 s.tick)
    else $error("tick spacing wrong");

  a_gate_capture: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    gate_end |=> s.evt_prev == $past(s.evt_cur) && s.evt_cur == 32'h0000_0000)
    else $error("gate end capture wrong");

  a_gate_hold: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (!gate && !gate_end) |=> $stable(s.evt_cur))
    else $error("count moved outside gate");

  a_no_retrigger: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (s.dly_state == cctu_pkg::CCTU_DLY_WAIT && !dly_ev) |=> $stable(s.dly_cnt))
    else $error("delay reloaded while pending");

  a_mono_start: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (s.dtrig && s.mono0_w != 32'h0000_0000 && s.mono1_w != 32'h0000_0000)
      |=> o_exposure_sync_pulse && o_pixel_reset_pulse)
    else $error("monostables did not start together");

  a_astable_range: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    o_astable_pulse |-> s.ast_cnt == 32'h0000_0000 && period_eff >= `CCTU_AST_MIN_US)
    else $error("astable wrap wrong");

  a_astable_pulse: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (enable && s.tick && s.ast_cnt == period_eff - 32'h0000_0001) |=> o_astable_pulse)
    else $error("astable pulse missing");

  a_opto_soft: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (s.opto_cfg[`CCTU_OPTO_SRC0_HI:`CCTU_OPTO_SRC0_LO] == 2'h0)
      |=> o_opto_out[0] == $past(s.opto_cfg[`CCTU_OPTO_SW_LO]))
    else $error("opto software level wrong");

  a_delay_direct: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (s.dly_state == cctu_pkg::CCTU_DLY_IDLE && trig_ev && s.delay_v == 32'h0000_0000)
      |=> o_delayed_trigger)
    else $error("zero delay trigger missing");

  a_area_source: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (s.dly_state == cctu_pkg::CCTU_DLY_IDLE && !s.ctrl[`CCTU_CTRL_LSCAN] &&
     s.ctrl[`CCTU_CTRL_SRC_HI:`CCTU_CTRL_SRC_LO] == 3'h4) |=> !o_delayed_trigger)
    else $error("frame valid trigger outside line scan");

  a_evt_count: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (gate && cnt_ev) |=> s.evt_cur == $past(s.evt_cur) + 32'h0000_0001)
    else $error("gated event not counted");

  a_bus_answer: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    ((i_avs_read || i_avs_write) && o_avs_waitrequest) |=> !o_avs_waitrequest)
    else $error("bus answer late");

endmodule

// File: verification/cctu_cam_model.sv
`timescale 1ns/1ps
module cctu_cam_model (
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire logic [7:0] i_lines,
  output logic            o_frame_valid,
  output logic            o_line_valid
);
  initial begin
    o_frame_valid = 1'b0;
    o_line_valid  = 1'b0;
  end
  // Frame valid drops only after the last blank span, so a frame gate never cuts a line short.
  always begin
    @(posedge i_clk);
    if (i_go) begin
      o_frame_valid <= 1'b1;
      repeat (4) @(posedge i_clk);
      for (int n = 0; n < int'(i_lines); n++) begin
        o_line_valid <= 1'b1;
        repeat (8) @(posedge i_clk);
        o_line_valid <= 1'b0;
        repeat (8) @(posedge i_clk);
      end
      o_frame_valid <= 1'b0;
    end
  end
endmodule

// File: verification/tb.sv
`timescale 1ns/1ps
`include "cctu_params.svh"
module tb;
  typedef struct packed {
    logic        w;
    logic [5:0]  a;
    logic [31:0] d;
  } cctu_row_s;
  logic        i_ref_clk = 1'b0;
  logic        i_reset_n;
  logic [5:0]  i_avs_address;
  logic        i_avs_read;
  logic        i_avs_write;
  logic [31:0] i_avs_writedata;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest;
  logic        i_frame_valid;
  logic        i_line_valid;
  logic [1:0]  i_opto_in;
  logic [1:0]  i_diff_in;
  logic        o_exposure_sync_pulse;
  logic        o_pixel_reset_pulse;
  logic        o_delayed_trigger;
  logic        o_astable_pulse;
  logic [1:0]  o_opto_out;
  logic        cam_go;
  logic [7:0]  cam_lines;
  logic        lv_d = 1'b0;
  logic        ast_d = 1'b0;
  logic        dtrig_d = 1'b0;
  logic        opto_mode = 1'b0;
  logic [31:0] q;
  int          mismatches, checked, cyc, ndtrig, t_dtrig, t_ast, ast_gap, t0;
  int          exp_hi, pix_hi, opto0_hi, lv_rises, lv_at_dtrig, b0, b1, b2, b3, opto_bad;
  // Reads carry the expected word in d; writes carry the data.
  cctu_row_s   rows [14] = '{
    '{1'b0, `CCTU_OFF_CTRL, 32'h0}, '{1'b0, `CCTU_OFF_PERIOD, 32'h1},
    '{1'b0, `CCTU_OFF_MONO0, 32'h0}, '{1'b0, `CCTU_OFF_MONO1, 32'h0},
    '{1'b0, `CCTU_OFF_DELAY, 32'h0}, '{1'b0, `CCTU_OFF_EVT_CUR, 32'h0},
    '{1'b0, `CCTU_OFF_EVT_PREV, 32'h0}, '{1'b0, `CCTU_OFF_OPTO, 32'h0},
    '{1'b0, `CCTU_OFF_STATUS, 32'h0}, '{1'b0, 6'h24, 32'h0},
    '{1'b1, `CCTU_OFF_MONO1, 32'hdead_beef}, '{1'b0, `CCTU_OFF_MONO1, 32'hdead_beef},
    '{1'b1, `CCTU_OFF_EVT_PREV, 32'h5}, '{1'b0, `CCTU_OFF_EVT_PREV, 32'h0}};

  always #2 i_ref_clk = ~i_ref_clk;

  cctu_top u_cctu_top (.i_ref_clk, .i_reset_n, .i_avs_address, .i_avs_read, .i_avs_write,
    .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .i_frame_valid, .i_line_valid,
    .i_opto_in, .i_diff_in, .o_exposure_sync_pulse, .o_pixel_reset_pulse,
    .o_delayed_trigger, .o_astable_pulse, .o_opto_out);
  cctu_cam_model u_cctu_cam_model (.i_clk(i_ref_clk), .i_go(cam_go), .i_lines(cam_lines),
    .o_frame_valid(i_frame_valid), .o_line_valid(i_line_valid));

  always @(posedge i_ref_clk) begin
    if (o_delayed_trigger === 1'b1) begin
      ndtrig++;
      t_dtrig = cyc;
      lv_at_dtrig = lv_rises;
    end
    if (o_astable_pulse === 1'b1) begin
      ast_gap = cyc - t_ast;
      t_ast = cyc;
    end
    if (o_exposure_sync_pulse === 1'b1) exp_hi++;
    if (o_pixel_reset_pulse === 1'b1) pix_hi++;
    if (o_opto_out[0] === 1'b1) opto0_hi++;
    if (i_line_valid && !lv_d) lv_rises++;
    lv_d = i_line_valid;
    // Each opto output lags its timer source by one cycle.
    if (opto_mode && o_opto_out !== {dtrig_d, ast_d}) opto_bad++;
    {dtrig_d, ast_d} = {o_delayed_trigger, o_astable_pulse};
    cyc++;
  end

  task automatic complete_run();
    if (mismatches == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic in_range(input int v, input int lo, input int hi, input string what);
    check(32'(v >= lo && v <= hi), 32'h1, what);
  endtask

  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    i_avs_read <= ~w;
    i_avs_write <= w;
    i_avs_address <= a;
    i_avs_writedata <= d;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    q = o_avs_readdata;
    if (n >= 50) check(32'h0, 32'h1, "bus answer");
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(q, exp, "register read");
  endtask

  task automatic trig(input int src, input int hold);
    @(posedge i_ref_clk);
    {i_diff_in, i_opto_in} <= 4'(1 << src);
    repeat (hold) @(posedge i_ref_clk);
    {i_diff_in, i_opto_in} <= 4'h0;
  endtask

  task automatic run_frame(input logic [7:0] n);
    int k;
    k = 0;
    @(posedge i_ref_clk);
    cam_lines <= n;
    cam_go <= 1'b1;
    @(posedge i_ref_clk);
    cam_go <= 1'b0;
    do begin
      @(posedge i_ref_clk);
      k++;
    end while (i_frame_valid !== 1'b0 && k < 2000);
    if (k >= 2000) check(32'h0, 32'h1, "frame end");
    repeat (4) @(posedge i_ref_clk);
  endtask

  initial begin
    repeat (40000) @(posedge i_ref_clk);
    mismatches++;
    complete_run();
  end

  initial begin
    {i_reset_n, i_avs_read, i_avs_write, cam_go} = 4'h0;
    {i_avs_address, i_avs_writedata, i_opto_in, i_diff_in, cam_lines} = 'h0;
    repeat (8) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    @(posedge i_ref_clk);
    foreach (rows[i]) begin
      if (rows[i].w) bus(1'b1, rows[i].a, rows[i].d);
      else rd(rows[i].a, rows[i].d);
    end
    bus(1'b1, `CCTU_OFF_OPTO, 32'h30);
    repeat (3) @(posedge i_ref_clk);
    check(32'(o_opto_out), 32'h3, "software opto levels");
    bus(1'b1, `CCTU_OFF_MONO0, 32'h3);
    bus(1'b1, `CCTU_OFF_MONO1, 32'h1);
    bus(1'b1, `CCTU_OFF_OPTO, 32'h2);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, `CCTU_OFF_CTRL, 32'h5 | 32'(s << 3));
      {b0, b1, b2, b3} = {ndtrig, exp_hi, pix_hi, opto0_hi};
      trig(s, 5);
      repeat (1000) @(posedge i_ref_clk);
      check(32'(ndtrig - b0), 32'h1, "edge trigger count");
      in_range(exp_hi - b1, 2 * `CCTU_US_CYC, 3 * `CCTU_US_CYC, "exposure width");
      in_range(pix_hi - b2, 1, `CCTU_US_CYC, "pixel reset width");
      check(32'(opto0_hi - b3), 32'(exp_hi - b1), "opto follows exposure");
    end
    bus(1'b1, `CCTU_OFF_CTRL, 32'h1);
    b0 = ndtrig;
    trig(0, 6);
    repeat (1000) @(posedge i_ref_clk);
    in_range(ndtrig - b0, 2, 8, "level trigger count");
    bus(1'b1, `CCTU_OFF_DELAY, 32'h2);
    bus(1'b1, `CCTU_OFF_CTRL, 32'h5);
    {b0, t0} = {ndtrig, cyc};
    trig(0, 3);
    repeat (100) @(posedge i_ref_clk);
    trig(0, 3);
    repeat (1000) @(posedge i_ref_clk);
    check(32'(ndtrig - b0), 32'h1, "pending delay drops trigger");
    in_range(t_dtrig - t0, `CCTU_US_CYC, 2 * `CCTU_US_CYC + 4, "delay in us");
    bus(1'b1, `CCTU_OFF_CTRL, 32'h25);
    b0 = ndtrig;
    run_frame(8'h1);
    check(32'(ndtrig - b0), 32'h0, "frame valid outside line scan");
    bus(1'b1, `CCTU_OFF_DELAY, 32'h3);
    bus(1'b1, `CCTU_OFF_CTRL, 32'h127);
    {b0, b1} = {ndtrig, lv_rises};
    run_frame(8'h5);
    check(32'(ndtrig - b0), 32'h1, "frame valid trigger");
    check(32'(lv_at_dtrig - b1), 32'h3, "delay in lines");
    repeat (1000) @(posedge i_ref_clk);
    bus(1'b1, `CCTU_OFF_CTRL, 32'h801);
    run_frame(8'h4);
    rd(`CCTU_OFF_EVT_PREV, 32'h4);
    rd(`CCTU_OFF_EVT_CUR, 32'h0);
    bus(1'b1, `CCTU_OFF_CTRL, 32'h1a01);
    run_frame(8'h1);
    run_frame(8'h1);
    rd(`CCTU_OFF_EVT_CUR, 32'h2);
    // Output 0 follows the astable pulse and output 1 the delayed trigger from here on.
    bus(1'b1, `CCTU_OFF_OPTO, 32'hd);
    repeat (2) @(posedge i_ref_clk);
    opto_mode <= 1'b1;
    bus(1'b1, `CCTU_OFF_CTRL, 32'h1401);
    trig(0, 1000);
    rd(`CCTU_OFF_EVT_PREV, 32'h4);
    for (int p = 1; p <= 2; p++) begin
      bus(1'b1, `CCTU_OFF_PERIOD, 32'(p));
      repeat (1600) @(posedge i_ref_clk);
      check(32'(ast_gap), 32'(p * `CCTU_US_CYC), "astable period");
    end
    check(32'(opto_bad), 32'h0, "opto timer sources");
    @(posedge i_ref_clk);
    i_reset_n <= 1'b0;
    opto_mode <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    check({27'h0, o_exposure_sync_pulse, o_pixel_reset_pulse, o_delayed_trigger,
           o_opto_out}, 32'h0, "outputs in reset");
    check(32'(o_astable_pulse), 32'h0, "astable in reset");
    i_reset_n <= 1'b1;
    @(posedge i_ref_clk);
    rd(`CCTU_OFF_CTRL, 32'h0);
    complete_run();
  end
endmodule
